// ===== src/tust_defines.vh
`ifndef TUST_DEFINES_VH
`define TUST_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// APB register map
`define TUST_ADDR_W         12
`define TUST_REG_CTRL       12'h000
`define TUST_REG_STATUS     12'h004
`define TUST_REG_SID        12'h008
`define TUST_REG_RESP       12'h00C
`define TUST_CTRL_RESET     2'h0
`define TUST_CTRL_CONN_BIT  0
`define TUST_CTRL_DENY_BIT  1
`define TUST_CTRL_W         2

////////////////////////////////////////////////////////////////////////////////
// Status register fields
`define TUST_ST_LOCK_BIT    0
`define TUST_ST_CONN_BIT    1
`define TUST_ST_PCIE_BIT    2
`define TUST_ST_SECOV_BIT   3
`define TUST_ST_RR_BIT      4
`define TUST_ST_POIS_BIT    5
`define TUST_ST_ECO_LSB     6
`define TUST_ST_CG_LSB      10
`define TUST_ST_TOK_LSB     16

////////////////////////////////////////////////////////////////////////////////
// Message link
`define TUST_MSG_W          160
`define TUST_KEEP_W         20
`define TUST_OP_LSB         0
`define TUST_OP_W           4
`define TUST_OP_CONNECT     4'h1
`define TUST_OP_SFM         4'h2
`define TUST_OP_TRANS_RESP  4'h3
`define TUST_TOK_LSB        4
`define TUST_TOK_FIELD_W    16
`define TUST_MSG_KEEP       20'h0000F
`define TUST_STAGE_REGIME_FIELD_LSB       4
`define TUST_STAGE_REGIME_FIELD_W         2
`define TUST_STAGE_REGIME_FIELD_EL1_S2    2'h2
`define TUST_AOVR_LSB       6
`define TUST_AOVR_W         8

////////////////////////////////////////////////////////////////////////////////
// Stream ID and memory types
`define TUST_SID_TOTAL_W    24
`define TUST_CACHE_NC_BUF   4'h3
`define TUST_POISON_GRAIN   64

`endif

// ===== src/tust_victim.v
`timescale 1ns/1ps
`include "tust_defines.vh"

module tust_victim #(
  parameter ENTRIES = 8,
  parameter IDX_W   = 3
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             rst_n,
  // Policy select
  input  wire             round_robin,
  // Entry use and allocation
  input  wire             touch_valid,
  input  wire [IDX_W-1:0] touch_idx,
  input  wire             alloc,
  // Entry to replace next
  output reg  [IDX_W-1:0] victim_idx
);

  reg [ENTRIES-1:0] plru_q;
  reg [ENTRIES-1:0] plru_d;
  reg [IDX_W-1:0]   rr_q;
  reg [IDX_W-1:0]   plru_victim;
  integer           lvl;
  integer           node;
  integer           lvl_t;
  integer           node_t;

  ////////////////////////////////////////////////////////////////////////////
  // Tree walk: each node bit points at the colder half
  always @* begin
    node = 1;
    plru_victim = {IDX_W{1'b0}};
    for (lvl = 0; lvl < IDX_W; lvl = lvl + 1) begin
      plru_victim = {plru_victim[IDX_W-2:0], plru_q[node]};
      node = 2 * node + plru_q[node];
    end
  end

  // Mark path of used entry as hot
  always @* begin
    plru_d = plru_q;
    node_t = 1;
    if (touch_valid) begin
      for (lvl_t = IDX_W - 1; lvl_t >= 0; lvl_t = lvl_t - 1) begin
        plru_d[node_t] = ~touch_idx[lvl_t];
        node_t = 2 * node_t + touch_idx[lvl_t];
      end
    end
  end

  always @* begin
    victim_idx = round_robin ? rr_q : plru_victim;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      plru_q <= {ENTRIES{1'b0}};
      rr_q   <= {IDX_W{1'b0}};
    end else begin
      plru_q <= plru_d;
      if (alloc && round_robin) begin
        rr_q <= rr_q + 1'b1;
      end
    end
  end

endmodule // tust_victim

// ===== src/tust_top.v
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tust_defines.vh"

module tust_top #(
  parameter SID_WIDTH   = 8,
  parameter XLATE_SLOTS = 16,
  parameter TOK_W       = 4,
  parameter DATA_WIDTH  = 128,
  parameter UTLB_ENT    = 8,
  parameter UTLB_IDX_W  = 3
) (
  // Clock and reset
  input  wire                             sys_clk,
  input  wire                             rst_n,
  // APB slave
  input  wire                             psel,
  input  wire                             penable,
  input  wire                             pwrite,
  input  wire [`TUST_ADDR_W-1:0]          paddr,
  input  wire [31:0]                      pwdata,
  input  wire                             pprot_ns,
  output wire                             pready,
  output reg  [31:0]                      prdata,
  output reg                              pslverr,
  // Clock-gate quiesce channel
  input  wire                             cg_quiesce_req_n,
  output wire                             cg_active_out,
  output wire                             cg_quiesce_accept_n,
  output wire                             cg_quiesce_deny,
  // Power-domain channel run indication
  input  wire                             pd_in_run,
  // Outgoing message link
  output reg                              msg_out_valid,
  input  wire                             msg_out_ready,
  output reg  [`TUST_MSG_W-1:0]           msg_out_data,
  output reg  [`TUST_KEEP_W-1:0]          msg_out_keep,
  output reg                              msg_out_last,
  output wire                             msg_out_wakeup,
  // Incoming message link
  input  wire                             msg_in_valid,
  output wire                             msg_in_ready,
  input  wire [`TUST_MSG_W-1:0]           msg_in_data,
  input  wire [`TUST_KEEP_W-1:0]          msg_in_keep,
  input  wire                             msg_in_last,
  input  wire                             msg_in_wakeup,
  // Interrupt edges
  output reg                              ras_fault_irq,
  output reg                              ras_recovery_irq,
  output reg                              ras_critical_irq,
  output reg                              pmu_irq,
  // Error and monitor events
  input  wire                             err_contained,
  input  wire                             err_uncontained,
  input  wire                             err_uncontainable,
  input  wire                             pmu_overflow,
  // Tie-offs
  input  wire [`TUST_SID_TOTAL_W-SID_WIDTH-1:0] nonsecure_stream_hi_bits,
  input  wire [`TUST_SID_TOTAL_W-SID_WIDTH-1:0] secure_stream_hi_bits,
  input  wire [TOK_W-1:0]                 token_count_tie,
  input  wire                             pcie_mode,
  input  wire                             sec_override,
  input  wire [3:0]                       eco_revision,
  input  wire                             utlb_round_robin,
  input  wire                             poison_support,
  // Transaction stream ID
  input  wire                             txn_valid,
  input  wire                             txn_secure,
  input  wire [SID_WIDTH-1:0]             txn_sid_low,
  input  wire [3:0]                       txn_cache,
  output reg  [`TUST_SID_TOTAL_W-1:0]     txn_stream_id,
  output reg                              txn_no_snoop,
  // Translation attribute results
  output reg                              xlat_merge_attrs,
  output reg  [`TUST_STAGE_REGIME_FIELD_W-1:0]          xlat_eff_regime,
  output reg  [`TUST_AOVR_W-1:0]          xlat_eff_override,
  // Write data path
  input  wire                             wd_in_valid,
  output wire                             wd_in_ready,
  input  wire [DATA_WIDTH-1:0]            wd_in_data,
  input  wire [DATA_WIDTH/`TUST_POISON_GRAIN-1:0] wd_in_err,
  output reg                              wd_out_valid,
  input  wire                             wd_out_ready,
  output reg  [DATA_WIDTH-1:0]            wd_out_data,
  output reg  [DATA_WIDTH/`TUST_POISON_GRAIN-1:0] wd_out_poison,
  // Micro-TLB replacement
  input  wire                             utlb_touch_valid,
  input  wire [UTLB_IDX_W-1:0]            utlb_touch_idx,
  input  wire                             utlb_alloc,
  output wire [UTLB_IDX_W-1:0]            utlb_victim_idx
);

  localparam HI_W   = `TUST_SID_TOTAL_W - SID_WIDTH;
  localparam PL_W   = DATA_WIDTH / `TUST_POISON_GRAIN;
  localparam TIE_W  = 2 * HI_W + TOK_W + 8;
  localparam CG_RUN = 6'h01;
  localparam CG_REQ = 6'h02;
  localparam CG_STP = 6'h04;
  localparam CG_EXT = 6'h08;
  localparam CG_DEN = 6'h10;
  localparam CG_CON = 6'h20;

  function [`TUST_MSG_W-1:0] build_msg;
    input [`TUST_OP_W-1:0]       op;
    input [`TUST_TOK_FIELD_W-1:0] tok;
    begin
      build_msg = {`TUST_MSG_W{1'b0}};
      build_msg[`TUST_OP_LSB +: `TUST_OP_W] = op;
      build_msg[`TUST_TOK_LSB +: `TUST_TOK_FIELD_W] = tok;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [TIE_W-1:0] tie_s1_q;
  reg [TIE_W-1:0] tie_s2_q;
  reg [2:0]       pin_s1_q;
  reg [2:0]       pin_s2_q;
  wire [TIE_W-1:0] tie_raw = {nonsecure_stream_hi_bits, secure_stream_hi_bits,
                              token_count_tie, pcie_mode, sec_override, eco_revision,
                              utlb_round_robin, poison_support};
  wire qreq_n_s = pin_s2_q[0];
  wire pd_run_s = pin_s2_q[1];
  wire wake_s   = pin_s2_q[2];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tie_s1_q <= {TIE_W{1'b0}};
      tie_s2_q <= {TIE_W{1'b0}};
      pin_s1_q <= 3'h1;
      pin_s2_q <= 3'h1;
    end else begin
      tie_s1_q <= tie_raw;
      tie_s2_q <= tie_s1_q;
      pin_s1_q <= {msg_in_wakeup, pd_in_run, cg_quiesce_req_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tie-off capture until first power-domain run
  reg             lock_q;
  reg [TIE_W-1:0] tie_q;
  wire [HI_W-1:0]  ns_hi_q  = tie_q[TIE_W-1 -: HI_W];
  wire [HI_W-1:0]  s_hi_q   = tie_q[TIE_W-HI_W-1 -: HI_W];
  wire [TOK_W-1:0] tok_q    = tie_q[8 +: TOK_W];
  wire             pcie_q   = tie_q[7];
  wire             secov_q  = tie_q[6];
  wire [3:0]       eco_q    = tie_q[5:2];
  wire             rr_q     = tie_q[1];
  wire             pois_q   = tie_q[0];
  wire [TOK_W:0]   tok_req  = {1'b0, tok_q} + 1'b1;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      tie_q  <= {TIE_W{1'b0}};
    end else if (!lock_q) begin
      tie_q  <= tie_s2_q;
      lock_q <= pd_run_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  reg [`TUST_CTRL_W-1:0] ctrl_q;
  reg                    conn_done_q;
  reg [5:0]              cg_q;
  reg [`TUST_STAGE_REGIME_FIELD_W-1:0] raw_stage_regime_field_q;
  reg [`TUST_AOVR_W-1:0] raw_aovr_q;
  wire setup  = psel && !penable;
  wire access = psel && penable;
  // Non-secure writes to control only when security override is set
  wire wr_ok  = !pprot_ns || secov_q;
  reg  [31:0] rd_val;
  reg         rd_err;

  assign pready = 1'b1;

  always @* begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `TUST_REG_CTRL: rd_val[`TUST_CTRL_W-1:0] = ctrl_q;
      `TUST_REG_STATUS: begin
        rd_val[`TUST_ST_LOCK_BIT]  = lock_q;
        rd_val[`TUST_ST_CONN_BIT]  = conn_done_q;
        rd_val[`TUST_ST_PCIE_BIT]  = pcie_q;
        rd_val[`TUST_ST_SECOV_BIT] = secov_q;
        rd_val[`TUST_ST_RR_BIT]    = rr_q;
        rd_val[`TUST_ST_POIS_BIT]  = pois_q;
        rd_val[`TUST_ST_ECO_LSB +: 4] = eco_q;
        rd_val[`TUST_ST_CG_LSB +: 6]  = cg_q;
        rd_val[`TUST_ST_TOK_LSB +: TOK_W+1] = tok_req;
      end
      `TUST_REG_SID: rd_val[2*HI_W-1:0] = {ns_hi_q, s_hi_q};
      `TUST_REG_RESP: rd_val[`TUST_STAGE_REGIME_FIELD_W+`TUST_AOVR_W-1:0] = {raw_aovr_q, raw_stage_regime_field_q};
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= `TUST_CTRL_RESET;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      if (setup) begin
        prdata  <= pwrite ? 32'h00000000 : rd_val;
        pslverr <= rd_err || (pwrite && paddr == `TUST_REG_CTRL && !wr_ok) ||
                   (pwrite && paddr != `TUST_REG_CTRL && !rd_err);
      end
      if (access && pwrite && paddr == `TUST_REG_CTRL && wr_ok) begin
        ctrl_q <= pwdata[`TUST_CTRL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing messages: connect, then failure-mode requests
  reg  sfm_pend_q;
  wire wbuf_err = wd_in_valid && wd_in_ready && (|wd_in_err);
  wire sfm_set  = wbuf_err && !pois_q;
  wire conn_want = lock_q && ctrl_q[`TUST_CTRL_CONN_BIT] && !conn_done_q;
  wire tx_busy   = msg_out_valid || conn_want || sfm_pend_q;

  assign msg_out_wakeup = tx_busy;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_out_valid <= 1'b0;
      msg_out_data  <= {`TUST_MSG_W{1'b0}};
      msg_out_keep  <= {`TUST_KEEP_W{1'b0}};
      msg_out_last  <= 1'b0;
      conn_done_q   <= 1'b0;
      sfm_pend_q    <= 1'b0;
    end else begin
      if (msg_out_valid && msg_out_ready) begin
        msg_out_valid <= 1'b0;
      end
      if (sfm_set) begin
        sfm_pend_q <= 1'b1;
      end
      if (!msg_out_valid || msg_out_ready) begin
        if (conn_want && !(msg_out_valid && msg_out_data[`TUST_OP_W-1:0] ==
            `TUST_OP_CONNECT)) begin
          msg_out_valid <= 1'b1;
          msg_out_data  <= build_msg(`TUST_OP_CONNECT,
                                     {{`TUST_TOK_FIELD_W-TOK_W-1{1'b0}}, tok_req});
          msg_out_keep  <= `TUST_MSG_KEEP;
          msg_out_last  <= 1'b1;
          conn_done_q   <= 1'b1;
        end else if (sfm_pend_q) begin
          msg_out_valid <= 1'b1;
          msg_out_data  <= build_msg(`TUST_OP_SFM, {`TUST_TOK_FIELD_W{1'b0}});
          msg_out_keep  <= `TUST_MSG_KEEP;
          msg_out_last  <= 1'b1;
          sfm_pend_q    <= sfm_set;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Incoming messages
  reg first_beat_q;
  assign msg_in_ready = (cg_q != CG_STP) && (cg_q != CG_EXT);
  wire in_fire = msg_in_valid && msg_in_ready;
  wire is_resp = first_beat_q && msg_in_keep[0] &&
                 msg_in_data[`TUST_OP_LSB +: `TUST_OP_W] == `TUST_OP_TRANS_RESP;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_beat_q      <= 1'b1;
      raw_stage_regime_field_q        <= {`TUST_STAGE_REGIME_FIELD_W{1'b0}};
      raw_aovr_q        <= {`TUST_AOVR_W{1'b0}};
      xlat_merge_attrs  <= 1'b0;
      xlat_eff_regime   <= {`TUST_STAGE_REGIME_FIELD_W{1'b0}};
      xlat_eff_override <= {`TUST_AOVR_W{1'b0}};
    end else begin
      if (in_fire) begin
        first_beat_q <= msg_in_last;
      end
      if (in_fire && is_resp) begin
        raw_stage_regime_field_q <= msg_in_data[`TUST_STAGE_REGIME_FIELD_LSB +: `TUST_STAGE_REGIME_FIELD_W];
        raw_aovr_q <= msg_in_data[`TUST_AOVR_LSB +: `TUST_AOVR_W];
      end
      xlat_merge_attrs  <= pcie_q || raw_stage_regime_field_q == `TUST_STAGE_REGIME_FIELD_EL1_S2;
      xlat_eff_regime   <= pcie_q ? `TUST_STAGE_REGIME_FIELD_EL1_S2 : raw_stage_regime_field_q;
      xlat_eff_override <= pcie_q ? {`TUST_AOVR_W{1'b0}} : raw_aovr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock-gate quiesce channel
  reg  [5:0] cg_d;
  wire busy = tx_busy || msg_in_valid || wake_s || wd_in_valid || wd_out_valid;

  assign cg_active_out       = busy;
  assign cg_quiesce_accept_n = !(cg_q == CG_STP || cg_q == CG_EXT && qreq_n_s == 1'b0);
  assign cg_quiesce_deny     = (cg_q == CG_DEN);

  always @* begin
    cg_d = cg_q;
    case (cg_q)
      CG_RUN: if (!qreq_n_s) cg_d = CG_REQ;
      CG_REQ: begin
        if (ctrl_q[`TUST_CTRL_DENY_BIT] || busy) begin
          cg_d = CG_DEN;
        end else begin
          cg_d = CG_STP;
        end
      end
      CG_STP: if (qreq_n_s) cg_d = CG_EXT;
      CG_EXT: cg_d = CG_RUN;
      CG_DEN: if (qreq_n_s) cg_d = CG_CON;
      CG_CON: cg_d = CG_RUN;
      default: cg_d = CG_RUN;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cg_q <= CG_RUN;
    end else begin
      cg_q <= cg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses, one cycle per event
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ras_fault_irq    <= 1'b0;
      ras_recovery_irq <= 1'b0;
      ras_critical_irq <= 1'b0;
      pmu_irq          <= 1'b0;
    end else begin
      ras_fault_irq    <= err_contained || sfm_set;
      ras_recovery_irq <= err_uncontained;
      ras_critical_irq <= err_uncontainable;
      pmu_irq          <= pmu_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream ID and memory type
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txn_stream_id <= {`TUST_SID_TOTAL_W{1'b0}};
      txn_no_snoop  <= 1'b0;
    end else if (txn_valid) begin
      txn_stream_id <= txn_secure ? {s_hi_q, txn_sid_low}
                                  : {ns_hi_q, txn_sid_low};
      txn_no_snoop  <= pcie_q && txn_cache == `TUST_CACHE_NC_BUF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data stage with poison
  assign wd_in_ready = !wd_out_valid || wd_out_ready;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_out_valid  <= 1'b0;
      wd_out_data   <= {DATA_WIDTH{1'b0}};
      wd_out_poison <= {PL_W{1'b0}};
    end else if (wd_in_ready) begin
      wd_out_valid  <= wd_in_valid;
      wd_out_data   <= wd_in_data;
      wd_out_poison <= (pois_q && wd_in_valid) ? wd_in_err
                                               : {PL_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Micro-TLB replacement
  tust_victim #(
    .ENTRIES (UTLB_ENT),
    .IDX_W   (UTLB_IDX_W)
  ) u_victim (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .round_robin (rr_q),
    .touch_valid (utlb_touch_valid),
    .touch_idx   (utlb_touch_idx),
    .alloc       (utlb_alloc),
    .victim_idx  (utlb_victim_idx)
  );

endmodule // tust_top

// ===== verification/tust_assertions.sv
`timescale 1ns/1ps
`include "tust_defines.vh"
module tust_assertions #(parameter DATA_WIDTH = 128) (
  // Clock and reset
  input wire logic sys_clk, rst_n,
  // Events and interrupts
  input wire logic err_contained, err_uncontained, err_uncontainable, pmu_overflow,
  input wire logic ras_fault_irq, ras_recovery_irq, ras_critical_irq, pmu_irq,
  // Outgoing link, quiesce channel, poison
  input wire logic msg_out_valid, msg_out_ready, msg_out_last,
  input wire logic [`TUST_MSG_W-1:0] msg_out_data,
  input wire logic [`TUST_KEEP_W-1:0] msg_out_keep,
  input wire logic cg_quiesce_accept_n, cg_quiesce_deny, poison_support,
  input wire logic [DATA_WIDTH/`TUST_POISON_GRAIN-1:0] wd_out_poison
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_FAULT: assert property (err_contained |=> ras_fault_irq)
    else $error("fault irq missing");
  AST_RECOV: assert property (ras_recovery_irq == $past(err_uncontained))
    else $error("recovery irq wrong");
  AST_CRIT: assert property (ras_critical_irq == $past(err_uncontainable))
    else $error("critical irq wrong");
  AST_PMU: assert property (pmu_irq == $past(pmu_overflow))
    else $error("monitor irq wrong");
  AST_BEAT: assert property (msg_out_valid |->
    msg_out_last && msg_out_keep == `TUST_MSG_KEEP)
    else $error("beat framing wrong");
  AST_HOLD: assert property (msg_out_valid && !msg_out_ready
    |=> msg_out_valid && $stable(msg_out_data))
    else $error("beat not held");
  AST_QCH: assert property (!(cg_quiesce_deny && !cg_quiesce_accept_n))
    else $error("accept and deny together");
  AST_NOPOIS: assert property (!poison_support |-> wd_out_poison == '0)
    else $error("poison while off");
endmodule // tust_assertions

bind tust_top tust_assertions #(.DATA_WIDTH(DATA_WIDTH)) u_tust_assertions (.*);

// ===== verification/tust_partner.sv
`timescale 1ns/1ps
`include "tust_defines.vh"
module tust_partner (
  // Clock and reset
  input  wire logic         sys_clk, rst_n,
  // Link from the block
  input  wire logic         msg_out_valid,
  input  wire logic [159:0] msg_out_data,
  output logic              msg_out_ready,
  // Link toward the block
  input  wire logic         msg_in_ready,
  output logic              msg_in_valid, msg_in_last, msg_in_wakeup,
  output logic [159:0]      msg_in_data,
  output logic [19:0]       msg_in_keep,
  // Test control
  input  wire logic         stall, send,
  input  wire logic [159:0] pkt,
  output logic [159:0]      got
);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {msg_out_ready, msg_in_valid, got} <= '0;
      msg_in_data <= '1;
    end else begin
      msg_out_ready <= !stall;
      if (msg_out_valid && msg_out_ready) got <= msg_out_data;
      if (send) {msg_in_valid, msg_in_data} <= {1'b1, pkt};
      else if (msg_in_valid && msg_in_ready)
        {msg_in_valid, msg_in_data} <= {1'b0, ~msg_in_data};
    end
  end
  // Idle lines show the inverse of the beat
  assign msg_in_keep   = msg_in_valid ? `TUST_MSG_KEEP : ~`TUST_MSG_KEEP;
  assign msg_in_last   = msg_in_valid;
  assign msg_in_wakeup = msg_in_valid | send;
endmodule // tust_partner

// ===== verification/testbench.sv
`timescale 1ns/1ps
`include "tust_defines.vh"
module testbench;
  logic sys_clk=0, rst_n=0, psel=0, penable=0, pwrite=0, pprot_ns=0, pready, pslverr, er;
  logic [11:0] paddr=0;
  logic [31:0] pwdata=0, prdata, rd;
  logic cg_quiesce_req_n=1, cg_active_out, cg_quiesce_accept_n, cg_quiesce_deny, pd_in_run=0;
  logic msg_out_valid, msg_out_ready, msg_out_last, msg_out_wakeup, msg_in_valid, msg_in_ready;
  logic msg_in_last, msg_in_wakeup, stall=0, send=0;
  logic [159:0] msg_out_data, msg_in_data, pkt=160'h1693, got;
  logic [19:0] msg_out_keep, msg_in_keep;
  logic [15:0] nonsecure_stream_hi_bits, secure_stream_hi_bits;
  logic [3:0] ev=0, token_count_tie, eco_revision=0, txn_cache=0;
  logic pcie_mode, sec_override, utlb_round_robin, poison_support, txn_valid=0, txn_secure=0;
  logic txn_no_snoop, xlat_merge_attrs, utlb_touch_valid=0, utlb_alloc=0, wd_in_valid=0;
  logic wd_in_ready, wd_out_valid, wd_out_ready=1;
  logic ras_fault_irq, ras_recovery_irq, ras_critical_irq, pmu_irq;
  logic [7:0] txn_sid_low=0, xlat_eff_override;
  logic [23:0] txn_stream_id;
  logic [1:0] xlat_eff_regime, wd_in_err=0, wd_out_poison;
  logic [127:0] wd_in_data=0, wd_out_data;
  logic [2:0] utlb_touch_idx=0, utlb_victim_idx;
  int checked=0, fails=0, cyc=0;
  wire err_contained, err_uncontained, err_uncontainable, pmu_overflow;
  assign {pmu_overflow, err_uncontainable, err_uncontained, err_contained} = ev;
  wire [3:0] irq = {pmu_irq, ras_critical_irq, ras_recovery_irq, ras_fault_irq};
  tust_top u_tust_top (.*);
  tust_partner u_tust_partner (.*);
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [159:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic phase(input logic [39:0] v);
    @(posedge sys_clk);
    rst_n <= 0;
    pd_in_run <= 0;
    {nonsecure_stream_hi_bits, secure_stream_hi_bits, token_count_tie,
     pcie_mode, sec_override, utlb_round_robin, poison_support} <= v;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    repeat (6) @(posedge sys_clk);
    pd_in_run <= 1;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic gotop(input logic [3:0] op);
    for (int i = 0; i < 40 && got[3:0] !== op; i++) @(negedge sys_clk);
  endtask
  task automatic txn(input logic s, input logic [7:0] lo, input logic [3:0] c);
    @(posedge sys_clk) {txn_valid, txn_secure, txn_sid_low, txn_cache} <= {1'b1, s, lo, c};
    @(posedge sys_clk) txn_valid <= 0;
    @(negedge sys_clk);
  endtask
  task automatic resp;
    @(posedge sys_clk) send <= 1;
    @(posedge sys_clk) send <= 0;
    do @(negedge sys_clk); while (msg_in_valid !== 1'b0);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic wd(input logic [1:0] e);
    @(posedge sys_clk) {wd_in_valid, wd_in_err, wd_in_data} <= {1'b1, e, {4{32'hC0DE1234}}};
    do @(posedge sys_clk); while (wd_in_ready !== 1'b1);
    wd_in_valid <= 0;
    do @(negedge sys_clk); while (wd_out_valid !== 1'b1);
  endtask
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    phase({16'hA5C3, 16'h3C5A, 4'h6, 4'hB});
    {pcie_mode, pprot_ns} <= 2'h1;
    apb(1, `TUST_REG_CTRL, 1);
    chk(er, 1);
    apb(0, 12'h010, 0);
    chk({er, rd}, {1'b1, 32'h0});
    {pprot_ns, stall} <= 2'h1;
    apb(1, `TUST_REG_CTRL, 1);
    repeat (4) @(negedge sys_clk);
    chk(msg_out_valid, 1);
    @(posedge sys_clk) stall <= 0;
    gotop(`TUST_OP_CONNECT);
    chk(got[19:0], 20'h00071);
    apb(0, `TUST_REG_STATUS, 0);
    chk(rd[19:0], 20'h70437);
    apb(0, `TUST_REG_SID, 0);
    chk(rd, 32'hA5C33C5A);
    txn(0, 8'h12, `TUST_CACHE_NC_BUF);
    chk({txn_stream_id, txn_no_snoop}, {24'hA5C312, 1'b1});
    txn(1, 8'h34, 4'hF);
    chk({txn_stream_id, txn_no_snoop}, {24'h3C5A34, 1'b0});
    resp;
    chk({xlat_merge_attrs, xlat_eff_regime, xlat_eff_override},
        {1'b1, `TUST_STAGE_REGIME_FIELD_EL1_S2, 8'h0});
    apb(0, `TUST_REG_RESP, 0);
    chk(rd[9:0], 10'h169);
    wd(2'h2);
    chk({wd_out_poison, wd_out_data}, {2'h2, {4{32'hC0DE1234}}});
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) ev <= 4'h1 << i;
      @(posedge sys_clk) ev <= 4'h0;
      @(negedge sys_clk) chk(irq, 4'h1 << i);
      @(negedge sys_clk) chk(irq, 4'h0);
    end
    @(posedge sys_clk) cg_quiesce_req_n <= 0;
    for (int i = 0; i < 20 && cg_quiesce_accept_n !== 1'b0; i++) @(negedge sys_clk);
    chk({cg_quiesce_accept_n, cg_quiesce_deny}, 2'h0);
    @(posedge sys_clk) cg_quiesce_req_n <= 1;
    for (int i = 0; i < 20 && cg_quiesce_accept_n !== 1'b1; i++) @(negedge sys_clk);
    chk({cg_quiesce_accept_n, cg_quiesce_deny}, 2'h2);
    apb(1, `TUST_REG_CTRL, 3);
    @(posedge sys_clk) cg_quiesce_req_n <= 0;
    for (int i = 0; i < 20 && cg_quiesce_deny !== 1'b1; i++) @(negedge sys_clk);
    chk({cg_quiesce_accept_n, cg_quiesce_deny}, 2'h3);
    @(posedge sys_clk) cg_quiesce_req_n <= 1;
    for (int i = 0; i < 20 && cg_quiesce_deny !== 1'b0; i++) @(negedge sys_clk);
    chk({cg_quiesce_accept_n, cg_quiesce_deny}, 2'h2);
    for (int i = 0; i < 9; i++) begin
      chk(utlb_victim_idx, i[2:0]);
      @(posedge sys_clk) utlb_alloc <= 1;
      @(posedge sys_clk) utlb_alloc <= 0;
      @(negedge sys_clk);
    end
    phase({16'h0F0F, 16'hF0F0, 4'h0, 4'h4});
    pprot_ns <= 1;
    apb(1, `TUST_REG_CTRL, 1);
    chk(er, 0);
    pprot_ns <= 0;
    gotop(`TUST_OP_CONNECT);
    chk(got[19:0], 20'h00011);
    chk(utlb_victim_idx, 3'h0);
    @(posedge sys_clk) {utlb_touch_valid, utlb_touch_idx} <= 4'h8;
    @(posedge sys_clk) utlb_touch_valid <= 0;
    @(negedge sys_clk) chk(utlb_victim_idx, 3'h4);
    wd(2'h1);
    chk({ras_fault_irq, wd_out_poison}, 3'h4);
    gotop(`TUST_OP_SFM);
    chk(got[3:0], `TUST_OP_SFM);
    resp;
    chk({xlat_eff_regime, xlat_eff_override}, {2'h1, 8'h5A});
    txn(0, 8'h01, `TUST_CACHE_NC_BUF);
    chk({txn_stream_id, txn_no_snoop}, {24'h0F0F01, 1'b0});
    summarize;
  end
endmodule // testbench
